// ---- verilog/ccs_consts.svh ----
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// register byte offsets on the apb bus
`define CCS_A_CTRL 12'h000
`define CCS_A_PATH 12'h004
`define CCS_A_LIVE 12'h008
`define CCS_A_ISTS 12'h00C
`define CCS_A_IMSK 12'h010
`define CCS_A_PIN0 12'h020

// control register fields
`define CCS_CTRL_MAIN_BIT 0
`define CCS_CTRL_ASYNC_BIT 1

// reset values
`define CCS_CTRL_RST 2'h0
`define CCS_IMSK_RST 12'h000
`define CCS_FN_RST 8'h00

// pin function codes
`define CCS_FN_SEQ_PULSE 8'h15
`define CCS_FN_CTRL_ERR 8'h16
`define CCS_FN_MAIN_EN 8'h4B
`define CCS_FN_ASYNC_EN 8'h4C
`define CCS_FN_UCLK_MAIN 8'h0A
`define CCS_FN_UCLK_ASYNC 8'h0B
`define CCS_FN_ADC_OVF 8'h17
`define CCS_FN_ADC_CIC 8'h18
`define CCS_FN_ADC_FIFO 8'h19
`define CCS_FN_MIX_DROP 8'h27
`define CCS_FN_UCLK_ANY 8'h2D
`define CCS_FN_OCLK 8'h2E

// event bit positions in the latched status register
`define CCS_EV_SEQ 0
`define CCS_EV_CERR 1
`define CCS_EV_MAIN 2
`define CCS_EV_ASYNC 3
`define CCS_EV_CLK0 4
`define CCS_EV_NUM 12

// timing
`define CCS_CLK_NS 8
`define CCS_SEQ_PULSE_NS 100

`endif

// ---- verilog/ccs_pkg.sv ----
package ccs_pkg;

    // sequencer completion pulse generator states
    typedef enum logic [0:0] {
        CCS_PS_IDLE = 1'b0,
        CCS_PS_HIGH = 1'b1
    } ccs_pstate_t;

    // index of each clocking error level inside the error vector
    typedef enum logic [2:0] {
        CCS_CE_UCLK_MAIN = 3'h0,
        CCS_CE_UCLK_ASYNC = 3'h1,
        CCS_CE_ADC_OVF = 3'h2,
        CCS_CE_ADC_CIC = 3'h3,
        CCS_CE_ADC_FIFO = 3'h4,
        CCS_CE_MIX_DROP = 3'h5,
        CCS_CE_UCLK_ANY = 3'h6,
        CCS_CE_OCLK = 3'h7
    } ccs_cerr_t;

endpackage

// ---- verilog/ccs_edge.sv ----
`timescale 1ns/1ns
`default_nettype none

// per-bit edge detector; masks choose which edges raise an event
module ccs_edge #(
    parameter int W = 1,
    parameter logic [W-1:0] RISE_MASK = '1,
    parameter logic [W-1:0] FALL_MASK = '0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] level,
    output logic [W-1:0] event_pulse
);

    logic [W-1:0] prev_q;

    // previous level; levels come from the same clock so no sync is needed
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end

    // one-cycle strobe per bit on the chosen edges
    genvar gi;
    for (gi = 0; gi < W; gi++) begin : g_bit
        assign event_pulse[gi] = (level[gi] & ~prev_q[gi] & RISE_MASK[gi]) |
                                 (~level[gi] & prev_q[gi] & FALL_MASK[gi]);
    end

endmodule

`default_nettype wire

// ---- verilog/ccs_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ccs_consts.svh"

//
// Functional notes
// - busy flag high while sequence runs or queued
// - pin function 15h gives 100ns done pulse
// - each finished sequence raises an event
// - event bits latch, readable, can drive irq
// - invalid register address flags control error
// - firmware access without clock flags error
// - control error event on rising edge only
// - registers reachable from host bus reads/writes
// - clock enable statuses selectable 4Bh, 4Ch
// - clock shutdown complete raises an event
// - flag underclocked errors, codes 0Ah and 0Bh
// - flag overclocked error as code 2Eh
// - reject underclocked path enable, keep others
// - clocking error events on both edges
// - 0Ah main underclock; set includes 17h, 27h (here 0Ah follows clk_err bit 0 alone)
// - 0Bh async clock underclock indication
// - 17h, 18h, 19h input path errors
// - 27h mixer dropped sample error
module ccs_top
    import ccs_pkg::*;
#(
    parameter int N_PINS = 4,
    parameter int N_PATHS = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic seq_running,
    input wire logic seq_queued,
    input wire logic seq_done,
    input wire logic acc_strobe,
    input wire logic acc_addr_bad,
    input wire logic acc_fw_mem,
    input wire logic fw_clk_en,
    input wire logic main_clk_sts,
    input wire logic async_clk_sts,
    input wire logic [7:0] clk_err,
    input wire logic [N_PATHS-1:0] path_ok,
    output logic main_clock_enable,
    output logic async_clock_enable_bit,
    output logic [N_PATHS-1:0] path_enable,
    output logic sequencer_busy_flag,
    output logic ctrl_err_out,
    output logic irq,
    output logic [N_PINS-1:0] pin_out
);

    // pulse length rounds up so the pin is never shorter than requested
    localparam int SEQ_PULSE_CYC = (`CCS_SEQ_PULSE_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS;
    localparam logic [11:0] PIN_END = 12'(`CCS_A_PIN0 + 4 * N_PINS);
    localparam int EVN = `CCS_EV_NUM;

    logic [1:0] ctrl_q;
    logic [N_PATHS-1:0] path_q;
    logic [EVN-1:0] ists_q;
    logic [EVN-1:0] imsk_q;
    logic [7:0] pin_fn_q [N_PINS];
    logic [N_PINS-1:0] pin_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic busy_q;
    logic ctrl_err_q;
    logic irq_q;
    ccs_pstate_t ps_q;
    logic [7:0] pcnt_q;

    // apb phases: first access cycle computes the answer, second completes it
    wire acc_first = psel & penable & ~pready_q;
    wire acc_done = psel & penable & pready_q;
    wire wr_done = acc_done & pwrite;
    wire hit_ctrl = (paddr == `CCS_A_CTRL);
    wire hit_path = (paddr == `CCS_A_PATH);
    wire hit_live = (paddr == `CCS_A_LIVE);
    wire hit_ists = (paddr == `CCS_A_ISTS);
    wire hit_imsk = (paddr == `CCS_A_IMSK);
    wire [11:0] pin_off = paddr - `CCS_A_PIN0;
    wire hit_pin = (paddr >= `CCS_A_PIN0) && (paddr < PIN_END) && (paddr[1:0] == 2'h0);
    wire mapped = hit_ctrl | hit_path | hit_live | hit_ists | hit_imsk | hit_pin;

    // control interface errors: bad address on either bus, or firmware memory
    // touched while its clock is off
    wire ext_bad = acc_strobe & (acc_addr_bad | (acc_fw_mem & ~fw_clk_en));
    wire apb_bad = acc_done & ~mapped;
    wire ctrl_err_d = ext_bad | apb_bad;

    // path enable: disables always pass, an enable needs enough clock cycles;
    // paths already running are left as they are
    wire [N_PATHS-1:0] path_w = pwdata[N_PATHS-1:0];
    wire [N_PATHS-1:0] path_d = (path_q & path_w) | (path_w & ~path_q & path_ok);

    // live status levels in event order, sequencer pulse in bit 0
    wire seq_pulse = (ps_q == CCS_PS_HIGH);
    wire [EVN-1:0] live_lvl = {clk_err, async_clk_sts, main_clk_sts, ctrl_err_q, seq_pulse};

    // event strobes: seq_done directly in bit 0, the rest from the edge detectors
    logic [10:0] edge_ev;
    wire [EVN-1:0] ev = {edge_ev, seq_done};

    ccs_edge #(
        .W(11),
        .RISE_MASK(11'b111_1111_1001),
        .FALL_MASK(11'b111_1111_1110)
    ) u_edge (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .level({clk_err, async_clk_sts, main_clk_sts, ctrl_err_q}),
        .event_pulse(edge_ev)
    );

    // write one to clear, a set in the same cycle wins
    wire [EVN-1:0] iclr = (wr_done & hit_ists) ? pwdata[EVN-1:0] : '0;
    wire [EVN-1:0] ists_d = (ists_q & ~iclr) | ev;

    // read mux for the pin function registers
    logic [7:0] pin_rd;
    always_comb begin
        pin_rd = '0;
        for (int i = 0; i < N_PINS; i++) begin
            if (pin_off[11:2] == 10'(i)) begin
                pin_rd = pin_rd | pin_fn_q[i];
            end
        end
    end

    wire [31:0] rd_data =
        hit_ctrl ? {30'h0, ctrl_q} :
        hit_path ? 32'(path_q) :
        hit_live ? 32'({live_lvl, busy_q}) :
        hit_ists ? 32'(ists_q) :
        hit_imsk ? 32'(imsk_q) :
        hit_pin ? {24'h0, pin_rd} : 32'h0000_0000;

    // apb answer, one wait state on every access
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc_first;
            pslverr_q <= acc_first & ~mapped;
            prdata_q <= (acc_first & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // clock enables and path enables written by software
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `CCS_CTRL_RST;
            path_q <= '0;
            imsk_q <= `CCS_IMSK_RST;
        end else begin
            if (wr_done & hit_ctrl) ctrl_q <= pwdata[1:0];
            if (wr_done & hit_path) path_q <= path_d;
            if (wr_done & hit_imsk) imsk_q <= pwdata[EVN-1:0];
        end
    end

    // latched events and the interrupt request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ists_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ists_q <= ists_d;
            irq_q <= |(ists_q & imsk_q);
        end
    end

    // busy and control error levels
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            ctrl_err_q <= 1'b0;
        end else begin
            busy_q <= seq_running | seq_queued;
            ctrl_err_q <= ctrl_err_d;
        end
    end

    // completion pulse once nothing is running or queued any more;
    // a new completion inside the pulse restarts it, so pulses merge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ps_q <= CCS_PS_IDLE;
            pcnt_q <= 8'h00;
        end else begin
            case (ps_q)
                CCS_PS_IDLE: begin
                    if (busy_q & ~(seq_running | seq_queued)) begin
                        ps_q <= CCS_PS_HIGH;
                        pcnt_q <= 8'(SEQ_PULSE_CYC - 1);
                    end
                end
                CCS_PS_HIGH: begin
                    if (busy_q & ~(seq_running | seq_queued)) begin
                        pcnt_q <= 8'(SEQ_PULSE_CYC - 1);
                    end else if (pcnt_q == 8'h00) begin
                        ps_q <= CCS_PS_IDLE;
                    end else begin
                        pcnt_q <= pcnt_q - 8'h01;
                    end
                end
                default: begin
                    ps_q <= CCS_PS_IDLE;
                end
            endcase
        end
    end

    // per-pin function register and registered pin level
    genvar gp;
    for (gp = 0; gp < N_PINS; gp++) begin : g_pin
        logic sel_val;
        wire fn_we = wr_done & hit_pin & (pin_off[11:2] == 10'(gp));

        // unknown codes drive low; other status sources live elsewhere
        always_comb begin
            case (pin_fn_q[gp])
                `CCS_FN_SEQ_PULSE: sel_val = seq_pulse;
                `CCS_FN_CTRL_ERR: sel_val = ctrl_err_q;
                `CCS_FN_MAIN_EN: sel_val = main_clk_sts;
                `CCS_FN_ASYNC_EN: sel_val = async_clk_sts;
                `CCS_FN_UCLK_MAIN: sel_val = clk_err[CCS_CE_UCLK_MAIN];
                `CCS_FN_UCLK_ASYNC: sel_val = clk_err[CCS_CE_UCLK_ASYNC];
                `CCS_FN_ADC_OVF: sel_val = clk_err[CCS_CE_ADC_OVF];
                `CCS_FN_ADC_CIC: sel_val = clk_err[CCS_CE_ADC_CIC];
                `CCS_FN_ADC_FIFO: sel_val = clk_err[CCS_CE_ADC_FIFO];
                `CCS_FN_MIX_DROP: sel_val = clk_err[CCS_CE_MIX_DROP];
                `CCS_FN_UCLK_ANY: sel_val = clk_err[CCS_CE_UCLK_ANY];
                `CCS_FN_OCLK: sel_val = clk_err[CCS_CE_OCLK];
                default: sel_val = 1'b0;
            endcase
        end

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                pin_fn_q[gp] <= `CCS_FN_RST;
                pin_q[gp] <= 1'b0;
            end else begin
                if (fn_we) pin_fn_q[gp] <= pwdata[7:0];
                pin_q[gp] <= sel_val;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign main_clock_enable = ctrl_q[`CCS_CTRL_MAIN_BIT];
    assign async_clock_enable_bit = ctrl_q[`CCS_CTRL_ASYNC_BIT];
    assign path_enable = path_q;
    assign sequencer_busy_flag = busy_q;
    assign ctrl_err_out = ctrl_err_q;
    assign irq = irq_q;
    assign pin_out = pin_q;

    // checks on the logic above
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_BUSY: assert property (
        (seq_running | seq_queued) |=> sequencer_busy_flag)
        else $error("busy flag low while sequencer active");

    AST_SEQ_PULSE: assert property (
        (busy_q && !(seq_running | seq_queued)) |=> seq_pulse [*8])
        else $error("completion pulse too short");

    AST_SEQ_EVENT: assert property (
        seq_done |=> ists_q[`CCS_EV_SEQ])
        else $error("sequence completion not latched");

    AST_STICKY: assert property (
        (ists_q[`CCS_EV_MAIN] && !iclr[`CCS_EV_MAIN]) |=> ists_q[`CCS_EV_MAIN])
        else $error("latched event lost without clear");

    AST_BAD_ADDR: assert property (
        (acc_first && !mapped) |=> (pslverr && pready) ##1 ctrl_err_out)
        else $error("unmapped access not flagged");

    AST_FW_NOCLK: assert property (
        (acc_strobe && acc_fw_mem && !fw_clk_en) |=> ctrl_err_out)
        else $error("firmware access without clock not flagged");

    AST_CERR_RISE: assert property (
        (!ists_q[`CCS_EV_CERR] && !ctrl_err_q && !$rose(ctrl_err_q)) |=> !ists_q[`CCS_EV_CERR])
        else $error("control error event without rising edge");

    AST_SHUTDOWN: assert property (
        $fell(main_clk_sts) |=> ists_q[`CCS_EV_MAIN])
        else $error("clock shutdown not latched");

    AST_PATH_REJECT: assert property (
        (wr_done && hit_path && !path_ok[0] && !path_q[0]) |=> !path_enable[0])
        else $error("underclocked path enabled");

    AST_CLKERR_EDGE: assert property (
        $changed(clk_err[CCS_CE_OCLK]) |=> ists_q[`CCS_EV_CLK0 + 7])
        else $error("clock error edge not latched");

    AST_PIN_FOLLOW: assert property (
        (pin_fn_q[0] == `CCS_FN_CTRL_ERR) |=> (pin_out[0] == $past(ctrl_err_q)))
        else $error("pin does not follow control error");

    COV_SEQ_PULSE: cover property ($rose(seq_pulse) ##1 pin_out[0]);
    COV_IRQ: cover property (ev[`CCS_EV_CERR] ##2 irq);
    COV_REJECT: cover property (wr_done && hit_path && (path_w & ~path_ok) != '0);

endmodule

`default_nettype wire

// ---- sim/ccs_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// host side of the register bus; requests change only just after a rising edge
module ccs_host_model (
    input wire logic core_clk,
    output var logic [11:0] paddr,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus from time zero
    initial begin
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end

    // one transfer; request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // wait for the answer; only the bench watchdog ends a dead wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- sim/test_control_clock_status_flags.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_control_clock_status_flags;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, exp_w;
    logic seq_running, seq_queued, seq_done, acc_strobe, acc_addr_bad, acc_fw_mem;
    logic fw_clk_en, main_clk_sts, async_clk_sts, main_clock_enable, async_clock_enable_bit;
    logic sequencer_busy_flag, ctrl_err_out, irq, err_prev, eflag;
    logic [7:0] clk_err, path_ok, path_enable, exp_p, w8, ok8;
    logic [3:0] pin_out;
    logic [7:0] codes [8] = '{8'h0A, 8'h0B, 8'h17, 8'h18, 8'h19, 8'h27, 8'h2D, 8'h2E};
    int errors = 0, samples_checked = 0, pulse_cyc = 0, err_cnt = 0, p0, e0;
    integer seed = 32'hf449;

    ccs_host_model host_u (.core_clk(core_clk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    ccs_top #(.N_PINS(4), .N_PATHS(8)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_running(seq_running),
        .seq_queued(seq_queued), .seq_done(seq_done), .acc_strobe(acc_strobe),
        .acc_addr_bad(acc_addr_bad), .acc_fw_mem(acc_fw_mem), .fw_clk_en(fw_clk_en),
        .main_clk_sts(main_clk_sts), .async_clk_sts(async_clk_sts), .clk_err(clk_err),
        .path_ok(path_ok), .main_clock_enable(main_clock_enable),
        .async_clock_enable_bit(async_clock_enable_bit), .path_enable(path_enable),
        .sequencer_busy_flag(sequencer_busy_flag), .ctrl_err_out(ctrl_err_out),
        .irq(irq), .pin_out(pin_out));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // count pulse width on pin 0 and rising edges of the error output
    always @(posedge core_clk) begin
        if (pin_out[0] === 1'b1) pulse_cyc <= pulse_cyc + 1;
        if (ctrl_err_out === 1'b1 && err_prev !== 1'b1) err_cnt <= err_cnt + 1;
        err_prev <= ctrl_err_out;
    end

    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rdat, eflag);
        // the write lands at the completing edge; let it settle before outputs are read
        tick(1);
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] x);
        host_u.xfer(1'b0, a, 32'h0000_0000, rdat, eflag);
        chk(n, x, rdat);
    endtask

    // one serial-side access reported by the other buses
    task automatic acc(input logic bad, input logic fw);
        @(posedge core_clk);
        acc_strobe <= 1'b1;
        acc_addr_bad <= bad;
        acc_fw_mem <= fw;
        @(posedge core_clk);
        acc_strobe <= 1'b0;
        tick(4);
    endtask

    // a path bit may be set only with enough cycles; clearing always works
    function automatic logic [7:0] exp_path(logic [7:0] old, logic [7:0] w, logic [7:0] ok);
        return w & (ok | old);
    endfunction

    // watchdog: the whole sequence needs far fewer cycles than this
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        report_and_stop();
    end

    initial begin
        {arst_n, seq_running, seq_queued, seq_done, acc_strobe, acc_addr_bad} = 6'h00;
        {acc_fw_mem, fw_clk_en} = 2'h0;
        main_clk_sts = 1'b1;
        async_clk_sts = 1'b1;
        clk_err = 8'h00;
        path_ok = 8'h00;
        exp_p = 8'h00;
        tick(20);
        arst_n <= 1'b1;
        rd_chk("ctrl_rst", 12'h000, 32'h0000_0000);
        rd_chk("live_rst", 12'h008, 32'h0000_0018);
        rd_chk("imsk_rst", 12'h010, 32'h0000_0000);
        rd_chk("pin_rst", 12'h020, 32'h0000_0000);
        wr(12'h000, 32'h0000_0003);
        chk("main_en", 32'h1, 32'(main_clock_enable));
        chk("async_en", 32'h1, 32'(async_clock_enable_bit));
        rd_chk("ctrl", 12'h000, 32'h0000_0003);
        // random path requests, including refusals
        for (int i = 0; i < 8; i++) begin
            ok8 = 8'($random(seed));
            w8 = (i == 0) ? 8'hFF : 8'($random(seed));
            path_ok <= ok8;
            tick(1);
            wr(12'h004, {24'h0, w8});
            exp_p = exp_path(exp_p, w8, ok8);
            chk("path", {24'h0, exp_p}, {24'h0, path_enable});
        end
        // busy follows running or queued work
        for (int i = 0; i < 10; i++) begin
            w8 = 8'($random(seed));
            seq_running <= w8[0];
            seq_queued <= w8[1];
            tick(2);
            chk("busy", 32'(w8[0] | w8[1]), 32'(sequencer_busy_flag));
        end
        seq_running <= 1'b0;
        seq_queued <= 1'b1;
        tick(20);
        wr(12'h020, 32'h0000_0015);
        wr(12'h010, 32'h0000_0003);
        wr(12'h00C, 32'h0000_0FFF);
        p0 = pulse_cyc;
        seq_queued <= 1'b0;
        seq_done <= 1'b1;
        tick(1);
        seq_done <= 1'b0;
        tick(20);
        chk("pulse_len", 32'd13, 32'(pulse_cyc - p0));
        rd_chk("ists_seq", 12'h00C, 32'h0000_0001);
        chk("irq_on", 32'h1, 32'(irq));
        tick(30);
        rd_chk("ists_held", 12'h00C, 32'h0000_0001);
        wr(12'h00C, 32'h0000_0001);
        tick(2);
        chk("irq_off", 32'h0, 32'(irq));
        // bad register accesses
        wr(12'h020, 32'h0000_0016);
        p0 = pulse_cyc;
        e0 = err_cnt;
        host_u.xfer(1'b1, 12'h0FC, 32'h0000_0001, rdat, eflag);
        chk("slverr_map", 32'h1, 32'(eflag));
        host_u.xfer(1'b0, 12'h002, 32'h0000_0000, rdat, eflag);
        chk("slverr_align", 32'h1, 32'(eflag));
        tick(3);
        chk("cerr_cnt", 32'(e0 + 2), 32'(err_cnt));
        acc(1'b0, 1'b1);
        chk("fw_noclk", 32'(e0 + 3), 32'(err_cnt));
        fw_clk_en <= 1'b1;
        acc(1'b0, 1'b1);
        chk("fw_clk", 32'(e0 + 3), 32'(err_cnt));
        acc(1'b1, 1'b0);
        chk("bad_addr", 32'(e0 + 4), 32'(err_cnt));
        chk("pin_cerr_cnt", 32'd4, 32'(pulse_cyc - p0));
        rd_chk("ists_cerr", 12'h00C, 32'h0000_0002);
        chk("irq_cerr", 32'h1, 32'(irq));
        wr(12'h00C, 32'h0000_0FFF);
        tick(3);
        rd_chk("ists_fall", 12'h00C, 32'h0000_0000);
        // clock enable status and shutdown events
        wr(12'h024, 32'h0000_004B);
        wr(12'h028, 32'h0000_004C);
        tick(3);
        chk("pin_main", 32'h1, 32'(pin_out[1]));
        chk("pin_async", 32'h1, 32'(pin_out[2]));
        wr(12'h000, 32'h0000_0002);
        chk("main_dis", 32'h0, 32'(main_clock_enable));
        main_clk_sts <= 1'b0;
        tick(3);
        chk("pin_main0", 32'h0, 32'(pin_out[1]));
        rd_chk("ists_main", 12'h00C, 32'h0000_0004);
        wr(12'h00C, 32'h0000_0FFF);
        wr(12'h000, 32'h0000_0000);
        chk("async_dis", 32'h0, 32'(async_clock_enable_bit));
        async_clk_sts <= 1'b0;
        tick(3);
        rd_chk("ists_async", 12'h00C, 32'h0000_0008);
        // every clocking error code, both edges
        for (int i = 0; i < 8; i++) begin
            wr(12'h02C, {24'h0, codes[i]});
            wr(12'h00C, 32'h0000_0FFF);
            clk_err <= 8'h01 << i;
            tick(3);
            chk("pin_cerr", 32'h1, 32'(pin_out[3]));
            rd_chk("ists_rise", 12'h00C, 32'h1 << (4 + i));
            wr(12'h00C, 32'h0000_0FFF);
            clk_err <= 8'h00;
            tick(3);
            chk("pin_cerr0", 32'h0, 32'(pin_out[3]));
            rd_chk("ists_fall", 12'h00C, 32'h1 << (4 + i));
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
